// ### csr_pkg.sv
// Constants and types for the core special register block
package csr_pkg;
   // Register slot indices; the bus byte address is four times the index
   localparam logic [7:0] ADDR_SP = 8'h81;
   localparam logic [7:0] ADDR_DPL = 8'h82;
   localparam logic [7:0] ADDR_DPH = 8'h83;
   localparam logic [7:0] ADDR_PSW = 8'hD0;
   localparam logic [7:0] ADDR_ACC = 8'hE0;
   localparam logic [7:0] ADDR_AUX = 8'hF0;
   // Extra slots: counter low/high, operation control, bank base
   localparam logic [7:0] ADDR_PCL = 8'h40;
   localparam logic [7:0] ADDR_PCH = 8'h44;
   localparam logic [7:0] ADDR_OPCTL = 8'h48;
   localparam logic [7:0] ADDR_BANK = 8'h4C;
   // Status word bit positions
   localparam int PSW_CY = 7;
   localparam int PSW_AC = 6;
   localparam int PSW_F0 = 5;
   localparam int PSW_RS1 = 4;
   localparam int PSW_RS0 = 3;
   localparam int PSW_OV = 2;
   localparam int PSW_F1 = 1;
   localparam int PSW_P = 0;
   // Reset values
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] PSW_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Operation codes written to the control slot
   typedef enum logic [2:0]
   {
      CSR_OP_NONE = 3'h0,
      CSR_OP_ADD = 3'h1,
      CSR_OP_ADDC = 3'h2,
      CSR_OP_SUBB = 3'h3,
      CSR_OP_MUL = 3'h4,
      CSR_OP_DIV = 3'h5,
      CSR_OP_PUSH = 3'h6,
      CSR_OP_INCDP = 3'h7
   } csr_op_t;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : csr_pkg

// ### csr_core_regs.sv
// Core special registers behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module csr_core_regs
   import csr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [15:0] instruction_counter,
   output logic [7:0] stack_top_ptr,
   output logic [15:0] data_pointer_pair,
   output logic [7:0] bank_base
);

   typedef struct packed
   {
      logic [15:0] pc;
      logic [7:0] sp;
      logic [7:0] data_ptr_low_byte;
      logic [7:0] data_ptr_high_byte;
      logic [7:0] program_status_word;
      logic [7:0] acc;
      logic [7:0] aux;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_lane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } csr_state_t;

   csr_state_t cur;
   csr_state_t next_cur;

   // Register slot index from a byte address; lanes are not decoded
   function automatic logic [7:0] csr_slot(input logic [9:0] a);
      csr_slot = a[9:2];
   endfunction : csr_slot

   // Known register slot, shared by read and write decode
   function automatic logic csr_mapped(input logic [7:0] s);
      csr_mapped = (s == ADDR_SP) || (s == ADDR_DPL) || (s == ADDR_DPH) ||
         (s == ADDR_PSW) || (s == ADDR_ACC) || (s == ADDR_AUX) ||
         (s == ADDR_PCL) || (s == ADDR_PCH) || (s == ADDR_OPCTL) ||
         (s == ADDR_BANK);
   endfunction : csr_mapped

   // Odd parity of a byte
   function automatic logic csr_parity(input logic [7:0] v);
      csr_parity = ^v;
   endfunction : csr_parity

   // One register byte in the low lane of a read word
   function automatic logic [31:0] csr_word(input logic [7:0] v);
      csr_word = {24'h000000, v};
   endfunction : csr_word

   // Byte adder; subtract adds the complement, so bit 8 is not-borrow
   function automatic logic [8:0] csr_sum9(input logic [7:0] a,
      input logic [7:0] b, input logic c, input logic sub);
      logic [7:0] bb;
      logic cc;
      bb = sub ? ~b : b;
      cc = sub ? ~c : c;
      csr_sum9 = {1'b0, a} + {1'b0, bb} + {8'h00, cc};
   endfunction : csr_sum9

   // Nibble adder for the half carry, same complement trick
   function automatic logic [4:0] csr_sum5(input logic [3:0] a,
      input logic [3:0] b, input logic c, input logic sub);
      logic [3:0] bb;
      logic cc;
      bb = sub ? ~b : b;
      cc = sub ? ~c : c;
      csr_sum5 = {1'b0, a} + {1'b0, bb} + {4'h0, cc};
   endfunction : csr_sum5

   // Signed wrap: operand signs allow it and the result sign flipped
   function automatic logic csr_wrap(input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] r, input logic sub);
      logic can_wrap;
      can_wrap = sub ? (a[7] ^ b[7]) : ~(a[7] ^ b[7]);
      csr_wrap = can_wrap & (a[7] ^ r[7]);
   endfunction : csr_wrap

   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] opnd;
   logic cin;
   logic is_sub;
   logic [15:0] product;
   logic [7:0] quot;
   logic [7:0] remd;
   logic wr_go;
   logic rd_go;
   logic [7:0] wb;
   logic [2:0] op;
   logic [7:0] wr_slot;
   logic [7:0] rd_slot;

   // Bus handshakes, datapath and register updates for one cycle
   always_comb
   begin
      next_cur = cur;
      wb = cur.w_data;
      op = cur.w_data[2:0];
      wr_slot = cur.aw_addr;
      rd_slot = csr_slot(s_axi_araddr);
      // Accept address and data independently, either order
      if (s_axi_awvalid && !cur.aw_held)
      begin
         next_cur.aw_held = 1'b1;
         next_cur.aw_addr = csr_slot(s_axi_awaddr);
      end
      if (s_axi_wvalid && !cur.w_held)
      begin
         next_cur.w_held = 1'b1;
         next_cur.w_data = s_axi_wdata[7:0];
         next_cur.w_lane = s_axi_wstrb[0];
      end
      // Responses drop only when the master has taken them
      if (cur.bvalid && s_axi_bready)
      begin
         next_cur.bvalid = 1'b0;
      end
      if (cur.rvalid && s_axi_rready)
      begin
         next_cur.rvalid = 1'b0;
      end
      // A held write waits while its predecessor's answer is pending
      wr_go = cur.aw_held && cur.w_held && !cur.bvalid;
      rd_go = s_axi_arvalid && !cur.rvalid;

      // Datapath: the aux register is always the second operand
      opnd = cur.aux;
      is_sub = (op == CSR_OP_SUBB);
      // Plain add ignores the old carry; the other two use it
      cin = (op == CSR_OP_ADD) ? 1'b0 : cur.program_status_word[PSW_CY];
      sum9 = csr_sum9(cur.acc, opnd, cin, is_sub);
      sum5 = csr_sum5(cur.acc[3:0], opnd[3:0], cin, is_sub);
      // Operands widened first so the high product byte is kept
      product = 16'(cur.acc) * 16'(cur.aux);
      // Divide by zero: quotient all ones, remainder keeps the dividend
      quot = (cur.aux == 8'h00) ? 8'hFF : cur.acc / cur.aux;
      remd = (cur.aux == 8'h00) ? cur.acc : cur.acc % cur.aux;

      // Apply a completed write; a cleared lane strobe writes nothing
      if (wr_go)
      begin
         next_cur.aw_held = 1'b0;
         next_cur.w_held = 1'b0;
         next_cur.bvalid = 1'b1;
         next_cur.bresp = csr_mapped(wr_slot) ? RESP_OKAY : RESP_SLVERR;
         if (cur.w_lane)
         begin
            unique case (wr_slot)
               ADDR_SP:
               begin
                  next_cur.sp = wb;
               end
               ADDR_DPL:
               begin
                  next_cur.data_ptr_low_byte = wb;
               end
               ADDR_DPH:
               begin
                  next_cur.data_ptr_high_byte = wb;
               end
               ADDR_PSW:
               begin
                  // Parity bit is overwritten again below
                  next_cur.program_status_word = wb;
               end
               ADDR_ACC:
               begin
                  next_cur.acc = wb;
               end
               ADDR_AUX:
               begin
                  next_cur.aux = wb;
               end
               ADDR_PCL:
               begin
                  next_cur.pc[7:0] = wb;
               end
               ADDR_PCH:
               begin
                  next_cur.pc[15:8] = wb;
               end
               ADDR_OPCTL:
               begin
                  unique case (op)
                     CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB:
                     begin
                        next_cur.acc = sum9[7:0];
                        // Adder bit 8 is not-borrow when subtracting
                        next_cur.program_status_word[PSW_CY] = is_sub ^ sum9[8];
                        next_cur.program_status_word[PSW_AC] = is_sub ^ sum5[4];
                        next_cur.program_status_word[PSW_OV] =
                           csr_wrap(cur.acc, opnd, sum9[7:0], is_sub);
                     end
                     CSR_OP_MUL:
                     begin
                        next_cur.acc = product[7:0];
                        next_cur.aux = product[15:8];
                        next_cur.program_status_word[PSW_CY] = 1'b0;
                        // Wrap flag marks a product above one byte
                        next_cur.program_status_word[PSW_OV] = (product[15:8] != 8'h00);
                     end
                     CSR_OP_DIV:
                     begin
                        next_cur.acc = quot;
                        next_cur.aux = remd;
                        next_cur.program_status_word[PSW_CY] = 1'b0;
                        // Wrap flag marks a divide by zero
                        next_cur.program_status_word[PSW_OV] = (cur.aux == 8'h00);
                     end
                     CSR_OP_PUSH:
                     begin
                        // Pre-increment: first push after reset lands at 08H
                        next_cur.sp = cur.sp + 8'h01;
                     end
                     CSR_OP_INCDP:
                     begin
                        // Carry from the low byte ripples into the high byte
                        {next_cur.data_ptr_high_byte, next_cur.data_ptr_low_byte} =
                           {cur.data_ptr_high_byte, cur.data_ptr_low_byte} + 16'h0001;
                     end
                     CSR_OP_NONE:
                     begin
                        // Step the counter as one fetch would
                        next_cur.pc = cur.pc + 16'h0001;
                     end
                  endcase
               end
               default:
               begin
                  // Unmapped and read-only slots leave all register state alone
                  next_cur.pc = cur.pc;
               end
            endcase
         end
      end

      // Parity tracks whatever the accumulator will hold
      next_cur.program_status_word[PSW_P] = csr_parity(next_cur.acc);

      // Read data captured at the accepting edge, held until taken
      if (rd_go)
      begin
         next_cur.rvalid = 1'b1;
         next_cur.rresp = csr_mapped(rd_slot) ? RESP_OKAY : RESP_SLVERR;
         unique case (rd_slot)
            ADDR_SP:
            begin
               next_cur.rdata = csr_word(cur.sp);
            end
            ADDR_DPL:
            begin
               next_cur.rdata = csr_word(cur.data_ptr_low_byte);
            end
            ADDR_DPH:
            begin
               next_cur.rdata = csr_word(cur.data_ptr_high_byte);
            end
            ADDR_PSW:
            begin
               next_cur.rdata = csr_word(cur.program_status_word);
            end
            ADDR_ACC:
            begin
               next_cur.rdata = csr_word(cur.acc);
            end
            ADDR_AUX:
            begin
               next_cur.rdata = csr_word(cur.aux);
            end
            ADDR_PCL:
            begin
               next_cur.rdata = csr_word(cur.pc[7:0]);
            end
            ADDR_PCH:
            begin
               next_cur.rdata = csr_word(cur.pc[15:8]);
            end
            ADDR_BANK:
            begin
               // Base of the selected working bank, eight bytes per bank
               next_cur.rdata = csr_word({3'h0, cur.program_status_word[PSW_RS1],
                  cur.program_status_word[PSW_RS0], 3'h0});
            end
            default:
            begin
               // Unmapped slots and the write-only control slot read zero
               next_cur.rdata = 32'h00000000;
            end
         endcase
      end
   end

   // Single register stage for the whole state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Handshake state clears: slots free, no answers pending
         cur <= '0;
         cur.pc <= PC_RESET;
         cur.sp <= SP_RESET;
         cur.program_status_word <= PSW_RESET;
         cur.acc <= DATA_RESET;
         cur.aux <= DATA_RESET;
         cur.data_ptr_low_byte <= DATA_RESET;
         cur.data_ptr_high_byte <= DATA_RESET;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // Bus outputs straight from the state register
   assign s_axi_awready = !cur.aw_held;
   assign s_axi_wready = !cur.w_held;
   assign s_axi_bvalid = cur.bvalid;
   assign s_axi_bresp = cur.bresp;
   assign s_axi_arready = !cur.rvalid;
   assign s_axi_rvalid = cur.rvalid;
   assign s_axi_rdata = cur.rdata;
   assign s_axi_rresp = cur.rresp;
   // Core-facing views of the counter and pointers
   assign instruction_counter = cur.pc;
   assign stack_top_ptr = cur.sp;
   assign data_pointer_pair = {cur.data_ptr_high_byte, cur.data_ptr_low_byte};
   // Working bank base address: bank select times eight
   assign bank_base = {3'h0, cur.program_status_word[PSW_RS1], cur.program_status_word[PSW_RS0], 3'h0};

endmodule : csr_core_regs

// ### csr_core_regs_checker.sv
// Bus timing and register checks on the special register block ports
`timescale 1ns/100ps
module csr_core_regs_checker
   import csr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] instruction_counter,
   input wire logic [7:0] stack_top_ptr,
   input wire logic [7:0] bank_base
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Address and data taken at the same edge
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_start;
      $rose(s_axi_bvalid);
   endsequence
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp moved");
   a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("arready not free");
   a_write_answer: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_resp_after_w: assert property (resp_start |-> !$past(s_axi_wready))
      else $error("resp without data");
   a_bank_map: assert property (bank_base inside
      {8'h00, 8'h08, 8'h10, 8'h18}) else $error("bank base off");
   a_reset_vals: assert property ($rose(aresetn) |->
      instruction_counter == PC_RESET && stack_top_ptr == SP_RESET)
      else $error("reset values wrong");
   // Counter and stack move only by a completed write
   a_regs_on_write: assert property ($changed(stack_top_ptr) ||
      $changed(instruction_counter) |-> resp_start)
      else $error("register moved alone");
endmodule : csr_core_regs_checker

bind csr_core_regs csr_core_regs_checker csr_core_regs_checker_i (.aclk,
   .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .instruction_counter, .stack_top_ptr, .bank_base);

// ### csr_bus_master.sv
// Register bus master model standing in for the core datapath
`timescale 1ns/100ps
module csr_bus_master
(
   input wire logic aclk,
   output logic [9:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [9:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   output logic rready
);
   initial {awaddr, awvalid, wdata, wvalid, bready} = '0;
   initial {araddr, arvalid, rready} = '0;
   // Address and data offered together, each dropped at its taking edge;
   // the answer is taken at the edge where bvalid is seen with bready up
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awaddr <= {a, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (!aw_done && awready)
         begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready)
         begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   // Single read, slot index turned into a byte address
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= {a, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      rready <= 1'b0;
   endtask : rd
endmodule : csr_bus_master

// ### testbench.sv
// Self-checking bench for the core special register block
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
   $display("mismatch %0t got %0h exp %0h", $time, a, b); end end
module testbench;
   import csr_pkg::*;
   logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [9:0] awa, ara;
   logic [7:0] sp, bank;
   logic [31:0] wd, rd;
   logic [1:0] bresp, rresp, r;
   logic [15:0] pc, dp, prod;
   int bad_count = 0, comparisons = 0;
   csr_core_regs csr_core_regs_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .instruction_counter(pc),
      .stack_top_ptr(sp), .data_pointer_pair(dp), .bank_base(bank));
   csr_bus_master csr_bus_master_i (.aclk(aclk), .awaddr(awa),
      .awvalid(awv), .awready(awr), .wdata(wd), .wvalid(wv), .wready(wr),
      .bresp(bresp), .bvalid(bv), .bready(br), .araddr(ara),
      .arvalid(arv), .arready(arr), .rdata(rd), .rvalid(rv), .rready(rr));
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic results();
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task automatic wok(input logic [7:0] a, input logic [7:0] d);
      csr_bus_master_i.wr(a, d, r);
      `CHK(r, RESP_OKAY)
   endtask : wok
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      csr_bus_master_i.rd(a, d);
      `CHK(d, {24'h0, e})
   endtask : rchk
   // Hang guard, far above the few hundred cycles needed
   initial
   begin
      #200000;
      bad_count++;
      results();
   end
   initial
   begin
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(ADDR_SP, SP_RESET);
      rchk(ADDR_PSW, PSW_RESET);
      rchk(ADDR_PCH, PC_RESET[15:8]);
      `CHK(pc, PC_RESET)
      // Product split over both registers, flags from it
      prod = 16'h00C8 * 16'h0003;
      wok(ADDR_ACC, 8'hC8);
      wok(ADDR_AUX, 8'h03);
      wok(ADDR_OPCTL, {5'h0, CSR_OP_MUL});
      rchk(ADDR_ACC, prod[7:0]);
      rchk(ADDR_AUX, prod[15:8]);
      rchk(ADDR_PSW, {5'h0, |prod[15:8], 1'b0, ^prod[7:0]});
      wok(ADDR_ACC, 8'h64);
      wok(ADDR_AUX, 8'h07);
      wok(ADDR_OPCTL, {5'h0, CSR_OP_DIV});
      rchk(ADDR_ACC, 8'h64 / 8'h07);
      rchk(ADDR_AUX, 8'h64 % 8'h07);
      // Carry, half carry and signed wrap all at once
      wok(ADDR_ACC, 8'h8F);
      wok(ADDR_AUX, 8'h81);
      wok(ADDR_OPCTL, {5'h0, CSR_OP_ADD});
      rchk(ADDR_ACC, 8'h10);
      rchk(ADDR_PSW, 8'hC5);
      // Subtract with the carry left set by the add
      wok(ADDR_AUX, 8'h01);
      wok(ADDR_OPCTL, {5'h0, CSR_OP_SUBB});
      rchk(ADDR_ACC, 8'h0E);
      rchk(ADDR_PSW, 8'h41);
      for (int i = 0; i < 4; i++)
      begin
         wok(ADDR_PSW, 8'h22 | 8'(i << 3));
         `CHK(bank, 8'(i * 8))
         rchk(ADDR_BANK, 8'(i * 8));
         rchk(ADDR_PSW, 8'h23 | 8'(i << 3));
      end
      // Add with a carry that software set
      wok(ADDR_PSW, 8'h80);
      wok(ADDR_OPCTL, {5'h0, CSR_OP_ADDC});
      rchk(ADDR_ACC, 8'h10);
      rchk(ADDR_PSW, 8'h41);
      wok(ADDR_OPCTL, {5'h0, CSR_OP_PUSH});
      `CHK(sp, 8'h08)
      wok(ADDR_DPL, 8'hFF);
      wok(ADDR_DPH, 8'h12);
      `CHK(dp, 16'h12FF)
      wok(ADDR_OPCTL, {5'h0, CSR_OP_INCDP});
      `CHK(dp, 16'h1300)
      rchk(ADDR_DPL, 8'h00);
      rchk(ADDR_DPH, 8'h13);
      wok(ADDR_OPCTL, {5'h0, CSR_OP_NONE});
      `CHK(pc, 16'h0001)
      wok(ADDR_AUX, 8'hA5);
      rchk(ADDR_AUX, 8'hA5);
      csr_bus_master_i.wr(8'h10, 8'h55, r);
      `CHK(r, RESP_SLVERR)
      rchk(8'h10, 8'h00);
      `CHK(rresp, RESP_SLVERR)
      // Reset in mid-run restores counter, stack and status
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(ADDR_PSW, PSW_RESET);
      `CHK(pc, PC_RESET)
      `CHK(sp, SP_RESET)
      results();
   end
endmodule : testbench
